// File: src/irv_ext_edge.sv
// irv_ext_edge: synchronises one external pin and flags the chosen edge
// assumes the pin is asynchronous to clk
`timescale 1ns/1ps
module irv_ext_edge #(
    parameter bit RISING = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // pin
    input wire logic pin,
    // one-cycle edge pulse
    output logic edge_evt
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } irv_ee_s;

    irv_ee_s st_reg;
    irv_ee_s st_next;

    // two-stage sync, third stage only for the edge compare
    always_comb begin
        st_next.s1 = pin;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // a pin held high through reset gives no false rising edge only after s3 settles
    assign edge_evt = RISING ? (st_reg.s2 & ~st_reg.s3) : (~st_reg.s2 & st_reg.s3);
endmodule : irv_ext_edge

// File: src/irv_pend_latch.sv
// irv_pend_latch: one sticky pending flag with set priority over clear
// assumes set and clear come from logic on the same clock
`timescale 1ns/1ps
module irv_pend_latch (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // event and clear
    input wire logic set_evt,
    input wire logic clr,
    // state
    output logic pend
);
    typedef struct packed {
        logic pend;
    } irv_pl_s;

    irv_pl_s st_reg;
    irv_pl_s st_next;

    // set wins so an event in the clearing cycle is kept
    always_comb begin
        st_next = st_reg;
        if (clr) begin
            st_next.pend = 1'b0;
        end
        if (set_evt) begin
            st_next.pend = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pend = st_reg.pend;
endmodule : irv_pend_latch

// File: src/irv_pkg.sv
// irv_pkg: constants, vectors and types of the interrupt and reset vectoring block
// assumes one cpu clock domain; shared by the vectoring top and its helpers
package irv_pkg;

    // ------------------------------------------------------------
    // vector addresses, low byte of each two-byte vector
    // ------------------------------------------------------------
    localparam logic [15:0] VEC_RESET = 16'hFFFE;
    localparam logic [15:0] VEC_TRAP = 16'hFFFC;
    localparam logic [15:0] VEC_USB_ESUSP = 16'hFFFA;
    localparam logic [15:0] VEC_EXT = 16'hFFF8;
    localparam logic [15:0] VEC_TIMER = 16'hFFF6;
    localparam logic [15:0] VEC_I2C = 16'hFFF4;
    localparam logic [15:0] VEC_SCI = 16'hFFF2;
    localparam logic [15:0] VEC_USB_PERI = 16'hFFF0;

    // ------------------------------------------------------------
    // external lines and reset values
    // ------------------------------------------------------------
    localparam int EXT_LINES = 8;
    // bit i set: line i+1 is rising edge; lines 1,2,5,6 rising, 3,4,7,8 falling
    localparam logic [7:0] EXT_RISING_MASK = 8'h33;
    localparam logic [7:0] EXT_ENABLE_RST = 8'h00;
    localparam logic [15:0] EXT_ENABLE_ADDR = 16'h0008;
    localparam logic MASK_RST = 1'b1;

    // peripheral source index within the peripheral pending vector
    localparam int PERI_TIMER = 0;
    localparam int PERI_I2C = 1;
    localparam int PERI_SCI = 2;
    localparam int PERI_USB = 3;
    localparam int PERI_NUM = 4;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 25;
    localparam int STARTUP_CYCLES = 4096;
    localparam int STARTUP_W = 13;

    // ------------------------------------------------------------
    // sequencer states, gray along the entry path
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        IRV_STARTUP = 3'b000,
        IRV_RUN = 3'b001,
        IRV_SAVE = 3'b011,
        IRV_FETCH = 3'b010,
        IRV_SLEEP = 3'b110
    } irv_state_e;

    // selected source code
    typedef enum logic [2:0] {
        SRC_RESET = 3'h0,
        SRC_TRAP = 3'h1,
        SRC_ESUSP = 3'h2,
        SRC_EXT = 3'h3,
        SRC_TIMER = 3'h4,
        SRC_I2C = 3'h5,
        SRC_SCI = 3'h6,
        SRC_USBP = 3'h7
    } irv_src_e;

endpackage : irv_pkg

// File: src/irv_vectoring.sv
// irv_vectoring: interrupt and reset vectoring for an 8-bit cpu core
// assumes the core signals instruction boundaries, trap, return, wait, halt
// and performs the context save and vector fetch when told to
`timescale 1ns/1ps

// Operation
// - maskable requests serviced only while mask clear; otherwise kept pending
// - entry waits for the current instruction to finish
// - entry pushes program counter, x, accumulator and condition code
// - entry sets the interrupt mask bit
// - after save, program counter loads from selected vector and fetches
// - return from interrupt restores registers, mask ends cleared
// - fixed priority: reset, trap, end-suspend, pins, timer, i2c, sci, usb
// - two-byte vectors FFFC down to FFF0 per source
// - any reset fetches the vector at FFFE and FFFF
// - 4096 cycle start delay after oscillator restarts
// - trap enters regardless of the mask bit
// - every interrupt source wakes the cpu from wait
// - only pins, end-suspend or reset wake from halt
// - lines 1,2,5,6 rising edge; lines 3,4,7,8 falling edge
// - pin edge interrupts need line enable set and mask clear
// - peripheral flag interrupts need enable and mask clear, else pending
// - peripheral request cleared by zero write or access-then-register sequence
// - clearing sequence discards a disabled pending request
// - reset sets mask; entering wait or halt clears it
// - external enable register at 0008, resets to 00, one bit per line
// - enabled pins sharing a vector are ORed
module irv_vectoring #(
    parameter int STARTUP_DELAY = irv_pkg::STARTUP_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // external pins
    input wire logic [irv_pkg::EXT_LINES-1:0] ext_irq_pin,
    // external enable register write port
    input wire logic ext_irq_enable_we,
    input wire logic [7:0] ext_irq_enable_wdata,
    // usb end-suspend event
    input wire logic usb_esusp_evt,
    // peripheral flags, enables and clears
    input wire logic [irv_pkg::PERI_NUM-1:0] peri_flag_evt,
    input wire logic [irv_pkg::PERI_NUM-1:0] peri_enable,
    input wire logic [irv_pkg::PERI_NUM-1:0] peri_clear,
    // core status and requests
    input wire logic insn_boundary,
    input wire logic trap_exec,
    input wire logic return_from_interrupt,
    input wire logic mask_set_sw,
    input wire logic mask_clr_sw,
    input wire logic wait_exec,
    input wire logic halt_exec,
    input wire logic osc_active,
    input wire logic entry_done,
    // to the core
    output logic cpu_hold,
    output logic ctx_save_req,
    output logic vec_fetch_req,
    output logic [15:0] vec_addr,
    output logic [2:0] vec_src,
    output logic irq_mask,
    output logic in_wait,
    output logic in_halt,
    output logic osc_enable,
    output logic [7:0] ext_irq_enable_reg
);
    import irv_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        irv_state_e state;
        logic [STARTUP_W-1:0] cnt;
        logic mask;
        logic waiting;
        logic halted;
        logic trap_pend;
        logic rst_pend;
        logic esusp_pend;
        logic osc_en;
        logic save;
        logic fetch;
        logic [15:0] vaddr;
        irv_src_e src;
        logic [7:0] ext_en;
        logic hold;
    } irv_st_s;

    irv_st_s st_reg;
    irv_st_s st_next;

    localparam logic [STARTUP_W-1:0] DELAY_LAST = STARTUP_W'(STARTUP_DELAY - 1);

    logic [EXT_LINES-1:0] ext_edge;
    logic [EXT_LINES-1:0] ext_pend;
    logic [PERI_NUM-1:0] peri_pend;
    logic ext_req;
    logic [PERI_NUM-1:0] peri_req;
    logic esusp_req;
    logic any_maskable;
    logic halt_wake;
    logic [EXT_LINES-1:0] ext_clr;

    // ------------------------------------------------------------
    // pin edges and pending latches
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < EXT_LINES; gi++) begin : g_ext
            irv_ext_edge #(
                .RISING(EXT_RISING_MASK[gi])
            ) u_edge (
                .clk(clk),
                .srst(srst),
                .pin(ext_irq_pin[gi]),
                .edge_evt(ext_edge[gi])
            );
            irv_pend_latch u_pend (
                .clk(clk),
                .srst(srst),
                .set_evt(ext_edge[gi]),
                .clr(ext_clr[gi]),
                .pend(ext_pend[gi])
            );
        end
        for (gi = 0; gi < PERI_NUM; gi++) begin : g_peri
            irv_pend_latch u_pend (
                .clk(clk),
                .srst(srst),
                .set_evt(peri_flag_evt[gi]),
                .clr(peri_clear[gi]),
                .pend(peri_pend[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // request qualification
    // ------------------------------------------------------------
    // pending pin edges are dropped when their vector is taken
    always_comb begin
        ext_clr = '0;
        if (st_reg.save && st_reg.src == SRC_EXT) begin
            ext_clr = '1;
        end
    end

    // enabled lines ORed onto the shared vector
    assign ext_req = |(ext_pend & st_reg.ext_en);
    assign peri_req = peri_pend & peri_enable;
    assign esusp_req = st_reg.esusp_pend;
    assign any_maskable = ext_req | esusp_req | (|peri_req);
    // halt: only pins and end-suspend, peripherals stop anyway
    assign halt_wake = ext_req | esusp_req;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.save = 1'b0;
        st_next.fetch = 1'b0;
        // sticky software traps and end-suspend; end-suspend set wins over its entry clear, the trap entry clear wins over trap_exec
        if (usb_esusp_evt) begin
            st_next.esusp_pend = 1'b1;
        end
        if (trap_exec) begin
            st_next.trap_pend = 1'b1;
        end
        if (ext_irq_enable_we) begin
            st_next.ext_en = ext_irq_enable_wdata;
        end
        // software mask control
        if (mask_set_sw) begin
            st_next.mask = 1'b1;
        end
        if (mask_clr_sw || return_from_interrupt) begin
            st_next.mask = 1'b0;
        end
        unique case (st_reg.state)
            IRV_STARTUP: begin
                // oscillator restart wait, then vector fetch
                st_next.osc_en = 1'b1;
                if (!osc_active) begin
                    // count restarts if the oscillator drops
                    st_next.cnt = '0;
                end else if (st_reg.cnt == DELAY_LAST) begin
                    st_next.cnt = '0;
                    st_next.state = IRV_SAVE;
                end else begin
                    st_next.cnt = st_reg.cnt + 1'b1;
                end
            end
            IRV_RUN: begin
                if (insn_boundary) begin
                    if (st_reg.trap_pend || trap_exec) begin
                        st_next.src = SRC_TRAP;
                        st_next.vaddr = VEC_TRAP;
                        st_next.trap_pend = 1'b0;
                        st_next.state = IRV_SAVE;
                    end else if (!st_reg.mask && any_maskable) begin
                        st_next.state = IRV_SAVE;
                        if (esusp_req) begin
                            st_next.src = SRC_ESUSP;
                            st_next.vaddr = VEC_USB_ESUSP;
                        end else if (ext_req) begin
                            st_next.src = SRC_EXT;
                            st_next.vaddr = VEC_EXT;
                        end else if (peri_req[PERI_TIMER]) begin
                            st_next.src = SRC_TIMER;
                            st_next.vaddr = VEC_TIMER;
                        end else if (peri_req[PERI_I2C]) begin
                            st_next.src = SRC_I2C;
                            st_next.vaddr = VEC_I2C;
                        end else if (peri_req[PERI_SCI]) begin
                            st_next.src = SRC_SCI;
                            st_next.vaddr = VEC_SCI;
                        end else begin
                            st_next.src = SRC_USBP;
                            st_next.vaddr = VEC_USB_PERI;
                        end
                    end else if (wait_exec || halt_exec) begin
                        // sleep only with nothing to take
                        st_next.mask = 1'b0;
                        st_next.waiting = wait_exec;
                        st_next.halted = halt_exec && !wait_exec;
                        st_next.osc_en = !(halt_exec && !wait_exec);
                        st_next.state = IRV_SLEEP;
                    end
                end
            end
            IRV_SAVE: begin
                // reset source skips the push
                st_next.save = (st_reg.src != SRC_RESET);
                st_next.mask = 1'b1;
                if (st_reg.src == SRC_ESUSP) begin
                    st_next.esusp_pend = usb_esusp_evt;
                end
                st_next.state = IRV_FETCH;
            end
            IRV_FETCH: begin
                // request stands until the core acknowledges
                st_next.fetch = 1'b1;
                if (entry_done && st_reg.fetch) begin
                    st_next.fetch = 1'b0;
                    st_next.state = IRV_RUN;
                end
            end
            IRV_SLEEP: begin
                // wait wakes to run; halt restarts the oscillator first
                if (st_reg.waiting && any_maskable) begin
                    st_next.waiting = 1'b0;
                    st_next.state = IRV_RUN;
                end else if (st_reg.halted && halt_wake) begin
                    st_next.halted = 1'b0;
                    st_next.src = esusp_req ? SRC_ESUSP : SRC_EXT;
                    st_next.vaddr = esusp_req ? VEC_USB_ESUSP : VEC_EXT;
                    st_next.osc_en = 1'b1;
                    st_next.state = IRV_STARTUP;
                end
            end
            default: begin
                st_next.state = IRV_STARTUP;
            end
        endcase
        // hold is registered, so it follows the next state
        st_next.hold = (st_next.state != IRV_RUN);
    end

    // any reset loads the reset vector after the start delay
    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg <= '0;
            st_reg.state <= IRV_STARTUP;
            st_reg.hold <= 1'b1;
            st_reg.mask <= MASK_RST;
            st_reg.src <= SRC_RESET;
            st_reg.vaddr <= VEC_RESET;
            st_reg.ext_en <= EXT_ENABLE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs, all from flip-flops
    // ------------------------------------------------------------
    assign cpu_hold = st_reg.hold;
    assign ctx_save_req = st_reg.save;
    assign vec_fetch_req = st_reg.fetch;
    assign vec_addr = st_reg.vaddr;
    assign vec_src = st_reg.src;
    assign irq_mask = st_reg.mask;
    assign in_wait = st_reg.waiting;
    assign in_halt = st_reg.halted;
    assign osc_enable = st_reg.osc_en;
    assign ext_irq_enable_reg = st_reg.ext_en;
endmodule : irv_vectoring

// File: verif/irv_core_model.sv
// irv_core_model: core side of the vector fetch and the oscillator
// assumes vec_fetch_req stays high until entry_done has been seen
`timescale 1ns/1ps
module irv_core_model (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // from the vectoring block
    input wire logic vec_fetch_req,
    input wire logic osc_enable,
    // fetch latency in cycles, set by the bench
    input wire logic [3:0] fetch_lat,
    // to the vectoring block
    output logic entry_done,
    output logic osc_active
);
    logic [3:0] cnt;
    logic [1:0] osc_pipe;
    // oscillator settles two cycles after enable; fetch done pulses once
    always_ff @(posedge clk) begin
        osc_pipe <= srst ? 2'h0 : {osc_pipe[0], osc_enable};
        if (srst || !vec_fetch_req)
            cnt <= 4'h0;
        else if (cnt != 4'hF)
            cnt <= cnt + 4'h1;
        entry_done <= !srst && vec_fetch_req && cnt == fetch_lat;
    end
    assign osc_active = osc_pipe[1];
endmodule : irv_core_model

// File: verif/irv_monitor.sv
// irv_monitor: port-level checks of the vectoring block
// assumes one clock domain and srst synchronous, active high
`timescale 1ns/1ps
module irv_monitor #(
    parameter int STARTUP_DELAY = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // watched inputs
    input wire logic [irv_pkg::EXT_LINES-1:0] ext_irq_pin,
    input wire logic ext_irq_enable_we,
    input wire logic usb_esusp_evt,
    input wire logic insn_boundary,
    input wire logic trap_exec,
    input wire logic return_from_interrupt,
    input wire logic wait_exec,
    input wire logic halt_exec,
    input wire logic osc_active,
    // watched outputs
    input wire logic cpu_hold,
    input wire logic ctx_save_req,
    input wire logic vec_fetch_req,
    input wire logic [15:0] vec_addr,
    input wire logic irq_mask,
    input wire logic in_wait,
    input wire logic in_halt,
    input wire logic [7:0] ext_irq_enable_reg
);
    import irv_pkg::*;
    logic [15:0] st_cnt;
    logic [3:0] quiet_cnt;
    logic [7:0] pin_d;
    // ----
    // helper counters
    // ----
    // oscillator run time, and quiet time of every halt wake source
    always_ff @(posedge clk) begin
        pin_d <= ext_irq_pin;
        if (srst || !osc_active || in_halt)
            st_cnt <= 16'h0000;
        else if (st_cnt != 16'hFFFF)
            st_cnt <= st_cnt + 16'h0001;
        if (srst || usb_esusp_evt || ext_irq_enable_we || ext_irq_pin != pin_d)
            quiet_cnt <= 4'h0;
        else if (quiet_cnt != 4'hF)
            quiet_cnt <= quiet_cnt + 4'h1;
    end
    // ----
    // assertions
    // ----
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    // hold, push, then fetch, one cycle apart
    sequence s_entry;
        cpu_hold ##1 (ctx_save_req && irq_mask) ##1 vec_fetch_req;
    endsequence
    reset_state_a: assert property (
        $fell(srst) |-> cpu_hold && irq_mask && vec_addr == VEC_RESET
            && ext_irq_enable_reg == EXT_ENABLE_RST)
        else $error("reset state wrong");
    startup_hold_a: assert property (
        $rose(vec_fetch_req) |-> st_cnt >= STARTUP_DELAY)
        else $error("fetch before start-up delay");
    trap_entry_a: assert property (
        insn_boundary && trap_exec && !cpu_hold |=> s_entry ##0 vec_addr == VEC_TRAP)
        else $error("trap entry sequence wrong");
    mask_block_a: assert property (
        insn_boundary && irq_mask && !cpu_hold && !trap_exec && !wait_exec && !halt_exec
            |=> !cpu_hold)
        else $error("entry while masked");
    save_pulse_a: assert property (
        ctx_save_req |-> cpu_hold ##1 (!ctx_save_req && vec_fetch_req))
        else $error("context save not followed by fetch");
    return_clear_a: assert property (
        return_from_interrupt && !cpu_hold |-> ##[1:2] !irq_mask)
        else $error("mask not cleared by return");
    wait_mask_a: assert property (
        insn_boundary && wait_exec && irq_mask && !cpu_hold && !trap_exec
            |=> ##[0:1] (in_wait && !irq_mask))
        else $error("wait entry left mask set");
    halt_stay_a: assert property (
        in_halt && quiet_cnt >= 4'h8 |=> in_halt)
        else $error("halt left without wake source");
endmodule : irv_monitor

bind irv_vectoring irv_monitor #(.STARTUP_DELAY(STARTUP_DELAY)) u_mon (
    .clk(clk), .srst(srst), .ext_irq_pin(ext_irq_pin),
    .ext_irq_enable_we(ext_irq_enable_we), .usb_esusp_evt(usb_esusp_evt),
    .insn_boundary(insn_boundary), .trap_exec(trap_exec),
    .return_from_interrupt(return_from_interrupt), .wait_exec(wait_exec),
    .halt_exec(halt_exec), .osc_active(osc_active), .cpu_hold(cpu_hold),
    .ctx_save_req(ctx_save_req), .vec_fetch_req(vec_fetch_req), .vec_addr(vec_addr),
    .irq_mask(irq_mask), .in_wait(in_wait), .in_halt(in_halt),
    .ext_irq_enable_reg(ext_irq_enable_reg)
);

// File: verif/irv_vectoring_test.sv
// irv_vectoring_test: directed bench for the vectoring block
// assumes the core model answers fetches and follows the oscillator
`timescale 1ns/1ps
module irv_vectoring_test;
    import irv_pkg::*;
    // ----
    // signals
    // ----
    localparam int SD = 8;
    localparam logic [16:0] B_BND = 17'h10000, B_TRAP = 17'h08000, B_WAIT = 17'h04000;
    localparam logic [16:0] B_HALT = 17'h02000, B_RET = 17'h01000, B_MCLR = 17'h00800;
    localparam logic [16:0] B_MSET = 17'h00400, B_ESUSP = 17'h00200, B_WE = 17'h00100;
    logic clk, srst, insn_boundary, trap_exec, wait_exec, halt_exec, return_from_interrupt;
    logic mask_clr_sw, mask_set_sw, usb_esusp_evt, ext_irq_enable_we, osc_active;
    logic entry_done, cpu_hold, ctx_save_req, vec_fetch_req, irq_mask, in_wait, in_halt;
    logic osc_enable;
    logic [2:0] vec_src;
    logic [3:0] peri_flag_evt, peri_clear, peri_enable, fetch_lat;
    logic [7:0] ext_irq_pin, ext_irq_enable_wdata, ext_irq_enable_reg;
    logic [15:0] vec_addr;
    logic [16:0] strb;
    int errors, total_checks;
    // all strobes in one vector, so a pulse is one assignment
    assign {insn_boundary, trap_exec, wait_exec, halt_exec, return_from_interrupt,
        mask_clr_sw, mask_set_sw, usb_esusp_evt, ext_irq_enable_we, peri_flag_evt,
        peri_clear} = strb;
    // 25 MHz clock
    always #20 clk = ~clk;
    irv_vectoring #(.STARTUP_DELAY(SD)) dut (
        .clk(clk), .srst(srst), .ext_irq_pin(ext_irq_pin),
        .ext_irq_enable_we(ext_irq_enable_we), .ext_irq_enable_wdata(ext_irq_enable_wdata),
        .usb_esusp_evt(usb_esusp_evt), .peri_flag_evt(peri_flag_evt),
        .peri_enable(peri_enable), .peri_clear(peri_clear), .insn_boundary(insn_boundary),
        .trap_exec(trap_exec), .return_from_interrupt(return_from_interrupt),
        .mask_set_sw(mask_set_sw), .mask_clr_sw(mask_clr_sw), .wait_exec(wait_exec),
        .halt_exec(halt_exec), .osc_active(osc_active), .entry_done(entry_done),
        .cpu_hold(cpu_hold), .ctx_save_req(ctx_save_req), .vec_fetch_req(vec_fetch_req),
        .vec_addr(vec_addr), .vec_src(vec_src), .irq_mask(irq_mask), .in_wait(in_wait),
        .in_halt(in_halt), .osc_enable(osc_enable), .ext_irq_enable_reg(ext_irq_enable_reg)
    );
    irv_core_model u_core (
        .clk(clk), .srst(srst), .vec_fetch_req(vec_fetch_req), .osc_enable(osc_enable),
        .fetch_lat(fetch_lat), .entry_done(entry_done), .osc_active(osc_active)
    );
    // ----
    // tasks
    // ----
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // one cycle of the given strobes
    task automatic pulse(input logic [16:0] v);
        @(posedge clk);
        strb <= v;
        @(posedge clk);
        strb <= '0;
    endtask : pulse
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test
    // bounded wait for the fetch, then the vector and the handshake tail
    task automatic expect_vec(input logic [15:0] v, output int n);
        n = 0;
        while (vec_fetch_req !== 1'b1 && n < 60) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 60) begin
            errors++;
            end_of_test();
        end
        chk("vec_addr", v, vec_addr);
        chk("vec_src", (16'hFFFE - v) >> 1, {13'h0, vec_src});
        tick(6);
    endtask : expect_vec
    // no entry may start during n cycles
    task automatic expect_none(input int n);
        int h;
        h = 0;
        repeat (n) begin
            @(posedge clk);
            #1;
            if (cpu_hold !== 1'b0)
                h++;
        end
        chk("hold_cycles", 16'h0, 16'(h));
    endtask : expect_none
    // ----
    // scenarios
    // ----
    initial begin
        int n;
        logic [15:0] pv [5];
        pv = '{VEC_USB_ESUSP, VEC_TIMER, VEC_I2C, VEC_SCI, VEC_USB_PERI};
        clk = 1'b0;
        srst = 1'b1;
        strb = '0;
        peri_enable = 4'hF;
        fetch_lat = 4'h0;
        ext_irq_pin = ~EXT_RISING_MASK;
        ext_irq_enable_wdata = 8'h00;
        errors = 0;
        total_checks = 0;
        // reset state, then the reset vector after the start-up delay
        tick(5);
        #1;
        chk("mask", 16'h1, {15'h0, irq_mask});
        chk("enable_reg", 16'h0, {8'h0, ext_irq_enable_reg});
        @(posedge clk);
        srst <= 1'b0;
        expect_vec(VEC_RESET, n);
        chk("startup", 16'h1, {15'h0, n >= SD});
        // a masked request waits until the mask clears
        pulse(17'h00010);
        pulse(B_BND);
        expect_none(6);
        pulse(B_MCLR);
        pulse(B_BND);
        expect_vec(VEC_TIMER, n);
        chk("mask_entry", 16'h1, {15'h0, irq_mask});
        pulse(17'h00001);
        pulse(B_RET);
        tick(1);
        #1;
        chk("mask_ret", 16'h0, {15'h0, irq_mask});
        // a disabled request is lost once its clearing sequence runs
        @(posedge clk);
        peri_enable <= 4'hD;
        pulse(17'h00020);
        pulse(B_BND);
        expect_none(6);
        pulse(17'h00002);
        @(posedge clk);
        peri_enable <= 4'hF;
        pulse(B_BND);
        expect_none(6);
        // end-suspend and all four peripheral sources at once, served in priority order at slower fetches
        pulse(17'h002F0);
        for (int k = 0; k < 5; k++) begin
            fetch_lat <= 4'(k);
            pulse(B_BND);
            expect_vec(pv[k], n);
            pulse(k == 0 ? 17'h0 : 17'h00001 << (k - 1));
            pulse(B_RET);
        end
        // trap enters even with the mask set
        pulse(B_MSET);
        pulse(B_BND | B_TRAP);
        expect_vec(VEC_TRAP, n);
        pulse(B_RET);
        // each line fires on its own edge only, through the shared vector
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            ext_irq_enable_wdata <= 8'h01 << i;
            pulse(B_WE);
            #1;
            chk("enable_reg", {8'h0, 8'h01 << i}, {8'h0, ext_irq_enable_reg});
            @(posedge clk);
            ext_irq_pin[i] <= ~ext_irq_pin[i];
            tick(5);
            pulse(B_BND);
            expect_vec(VEC_EXT, n);
            pulse(B_RET);
            @(posedge clk);
            ext_irq_pin[i] <= ~ext_irq_pin[i];
            tick(5);
            pulse(B_BND);
            expect_none(6);
        end
        // wait clears the mask; even the lowest source wakes it
        pulse(B_MSET);
        pulse(B_BND | B_WAIT);
        tick(1);
        #1;
        chk("wait_mask", 16'h0, {15'h0, irq_mask});
        pulse(17'h00080);
        tick(3);
        #1;
        chk("in_wait", 16'h0, {15'h0, in_wait});
        pulse(B_BND);
        expect_vec(VEC_USB_PERI, n);
        pulse(17'h00008);
        pulse(B_RET);
        // halt ignores peripheral sources, end-suspend wakes it
        pulse(B_BND | B_HALT);
        pulse(17'h00010);
        tick(10);
        #1;
        chk("in_halt", 16'h1, {15'h0, in_halt});
        pulse(17'h00001);
        pulse(B_ESUSP);
        expect_vec(VEC_USB_ESUSP, n);
        pulse(B_RET);
        // reset in mid-run restores defaults and refetches
        @(posedge clk);
        srst <= 1'b1;
        tick(2);
        srst <= 1'b0;
        expect_vec(VEC_RESET, n);
        chk("enable_reg", 16'h0, {8'h0, ext_irq_enable_reg});
        end_of_test();
    end
endmodule : irv_vectoring_test
